// *** spc_pkg.sv ***
// Operation
// - The chip identification word is a fixed read-only constant; only its low byte may change between revisions.
// - Bits 31:28 (reset all ones) select which of ten GPIOs drives GPIO interrupt 1; values above 9 select none.
// - Bits 27:24 (reset all ones) select which of ten GPIOs drives GPIO interrupt 0; values above 9 select none.
// - Bits 23..20 set the active level of port A valid, direction, enable and sync; 1 is high, each resets to 1.
// - Bits 19..16 set the active level of port B valid, direction, enable and sync; 1 is high, each resets to 1.
// - Bit 15 (reset 0) set to 1 turns off the bus-holder isolation of the PHY-link interface.
// - Bits 14:13, 11:10 and 7:6 ignore writes and always read as zero.
// - Bit 12 (reset 0) drives the contender pin as an output when 1 and leaves it an input when 0.
// - Bit 9 (reset 1) floats the host interrupt driver except while the interrupt is asserted.
// - Bit 8 (reset 1) floats the host acknowledge driver whenever acknowledge is not asserted.
// - The host acknowledge active level is written at write-only bit 5 and read at read-only bit 4, both reset 0.
// - Bit 3 (reset 0) sets the active level of the host strobe pin, 1 for high.
// - Bit 2 (reset 1) set means a high direction pin is a read; cleared means a high pin is a write.
// - Bit 1 (reset 0) sets the active level of the host select pin, 1 for high.
// - Bit 0 (reset 0) sets the active level of the host size pin, 1 for high.
package spc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] ADDR_CHIP_IDENT  = 12'h000;
    localparam logic [11:0] ADDR_PIN_SETUP   = 12'h004;

    // Arbitrary identification value, not tied to any real part
    localparam logic [31:0] CHIP_IDENT_VALUE = 32'h5AC3_1001;

    // ****************************************
    // Pin setup fields
    // ****************************************
    localparam logic [31:0] PIN_SETUP_RESET  = 32'hFFFF_0304;
    localparam logic [31:0] PIN_RW_MASK      = 32'hFFFF_930F;
    localparam logic [31:0] PIN_RSVD_MASK    = 32'h0000_6CC0;
    localparam int          IRQ1_SRC_LSB     = 28;
    localparam int          IRQ0_SRC_LSB     = 24;
    localparam int          PORT_A_POL_LSB   = 20;
    localparam int          PORT_B_POL_LSB   = 16;
    localparam int          ISOLATION_BIT    = 15;
    localparam int          CONTENDER_BIT    = 12;
    localparam int          IRQ_FLOAT_BIT    = 9;
    localparam int          ACK_FLOAT_BIT    = 8;
    localparam int          ACK_POL_WR_BIT   = 5;
    localparam int          ACK_POL_RD_BIT   = 4;
    localparam int          HOST_POL_LSB     = 0;
    localparam int          SRC_W            = 4;
    localparam int          GPIO_COUNT       = 10;
    localparam logic [3:0]  SRC_LAST         = 4'h9;

    // ****************************************
    // Bus responses
    // ****************************************
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

// *** spc_pol_sync.sv ***
module spc_pol_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Pin side
    input  wire logic [W-1:0] pin,
    input  wire logic [W-1:0] act_high,
    // Internal side, active high
    output logic      [W-1:0] level
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] level_q;

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    // ****************************************
    // Polarity correction
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= '0;
        end else begin
            level_q <= sync_q ~^ act_high;
        end
    end

    assign level = level_q;

endmodule

// *** spc_regs.sv ***
module spc_regs
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // GPIO pins and selected interrupt sources
    input  wire logic [9:0]        gpio_pin_i,
    output logic                   gpio_irq0_source,
    output logic                   gpio_irq1_source,
    // Stream port A pins and internal levels
    input  wire logic              port_a_valid_pin,
    input  wire logic              port_a_dir_pin,
    input  wire logic              port_a_enable_pin,
    input  wire logic              port_a_sync_pin,
    output logic                   port_a_valid,
    output logic                   port_a_dir,
    output logic                   port_a_enable,
    output logic                   port_a_sync,
    // Stream port B pins and internal levels
    input  wire logic              port_b_valid_pin,
    input  wire logic              port_b_dir_pin,
    input  wire logic              port_b_enable_pin,
    input  wire logic              port_b_sync_pin,
    output logic                   port_b_valid,
    output logic                   port_b_dir,
    output logic                   port_b_enable,
    output logic                   port_b_sync,
    // Host interface pins and internal levels
    input  wire logic              host_strobe_pin,
    input  wire logic              host_dir_pin,
    input  wire logic              host_select_pin,
    input  wire logic              host_size_pin,
    output logic                   host_strobe,
    output logic                   host_read,
    output logic                   host_select,
    output logic                   host_size32,
    // Host acknowledge pin
    input  wire logic              host_ack_req,
    output logic                   host_ack_pin_o,
    output logic                   host_ack_pin_oe,
    // Host interrupt pin, active low
    input  wire logic              host_irq_req,
    output logic                   host_irq_pin_o,
    output logic                   host_irq_pin_oe,
    // Contender pin
    input  wire logic              contender_drive,
    input  wire logic              contender_pin_i,
    output logic                   contender_pin_o,
    output logic                   contender_pin_oe,
    output logic                   contender_seen,
    // PHY-link isolation control
    output logic                   holder_isolation_off
);

    // ****************************************
    // Bus slave state
    // ****************************************
    logic              aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_held_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic [31:0]       pin_q;
    logic [31:0]       pin_d;
    logic              wr_go;
    logic              wr_pin;
    logic              wr_known;
    logic [ADDR_W-1:0] rd_word;
    logic [9:0]        gpio_lvl;
    logic [3:0]        irq0_sel;
    logic [3:0]        irq1_sel;
    logic              irq0_q;
    logic              irq1_q;
    logic              ack_o_q;
    logic              ack_oe_q;
    logic              irq_o_q;
    logic              irq_oe_q;
    logic              cont_o_q;
    logic              cont_oe_q;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign wr_go    = aw_held_q && w_held_q && !bvalid_q;
    assign wr_pin   = {aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_PIN_SETUP;
    assign wr_known = wr_pin
                   || ({aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_CHIP_IDENT);
    assign rd_word  = {s_axi_araddr[ADDR_W-1:2], 2'h0};

    // ****************************************
    // Write channel capture and response
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Pin setup next value
    // ****************************************
    always_comb begin
        pin_d = pin_q;
        for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) begin
                pin_d[8*b +: 8] = (w_data_q[8*b +: 8] & PIN_RW_MASK[8*b +: 8])
                        | (pin_q[8*b +: 8] & ~PIN_RW_MASK[8*b +: 8]);
            end
        end
        if (w_strb_q[0]) begin
            pin_d[ACK_POL_RD_BIT] = w_data_q[ACK_POL_WR_BIT];
        end
    end

    // ****************************************
    // Pin setup register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= PIN_SETUP_RESET;
        end else if (wr_go && wr_pin) begin
            pin_q <= pin_d;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            if (rd_word == ADDR_CHIP_IDENT) begin
                rdata_q <= CHIP_IDENT_VALUE;
            end else if (rd_word == ADDR_PIN_SETUP) begin
                rdata_q <= pin_q;
            end else begin
                rdata_q <= '0;
                rresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************
    // Input pins
    // ****************************************
    spc_pol_sync #(.W(GPIO_COUNT)) u_gpio (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      (gpio_pin_i),
        .act_high ({GPIO_COUNT{1'b1}}),
        .level    (gpio_lvl)
    );

    spc_pol_sync #(.W(4)) u_port_a (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      ({port_a_valid_pin, port_a_dir_pin,
                    port_a_enable_pin, port_a_sync_pin}),
        .act_high (pin_q[PORT_A_POL_LSB +: 4]),
        .level    ({port_a_valid, port_a_dir, port_a_enable, port_a_sync})
    );

    spc_pol_sync #(.W(4)) u_port_b (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      ({port_b_valid_pin, port_b_dir_pin,
                    port_b_enable_pin, port_b_sync_pin}),
        .act_high (pin_q[PORT_B_POL_LSB +: 4]),
        .level    ({port_b_valid, port_b_dir, port_b_enable, port_b_sync})
    );

    spc_pol_sync #(.W(4)) u_host (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      ({host_strobe_pin, host_dir_pin,
                    host_select_pin, host_size_pin}),
        .act_high (pin_q[HOST_POL_LSB +: 4]),
        .level    ({host_strobe, host_read, host_select, host_size32})
    );

    spc_pol_sync #(.W(1)) u_contender (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      (contender_pin_i),
        .act_high (1'b1),
        .level    (contender_seen)
    );

    // ****************************************
    // GPIO interrupt source select
    // ****************************************
    assign irq1_sel = pin_q[IRQ1_SRC_LSB +: SRC_W];
    assign irq0_sel = pin_q[IRQ0_SRC_LSB +: SRC_W];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq1_q <= 1'b0;
            irq0_q <= 1'b0;
        end else begin
            irq1_q <= (irq1_sel <= SRC_LAST) ? gpio_lvl[irq1_sel] : 1'b0;
            irq0_q <= (irq0_sel <= SRC_LAST) ? gpio_lvl[irq0_sel] : 1'b0;
        end
    end

    assign gpio_irq1_source = irq1_q;
    assign gpio_irq0_source = irq0_q;

    // ****************************************
    // Output pin drivers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_o_q   <= 1'b1;
            ack_oe_q  <= 1'b0;
            irq_o_q   <= 1'b1;
            irq_oe_q  <= 1'b0;
            cont_o_q  <= 1'b0;
            cont_oe_q <= 1'b0;
        end else begin
            ack_o_q   <= host_ack_req ~^ pin_q[ACK_POL_RD_BIT];
            ack_oe_q  <= !pin_q[ACK_FLOAT_BIT] || host_ack_req;
            irq_o_q   <= !host_irq_req;
            irq_oe_q  <= !pin_q[IRQ_FLOAT_BIT] || host_irq_req;
            cont_o_q  <= contender_drive;
            cont_oe_q <= pin_q[CONTENDER_BIT];
        end
    end

    assign host_ack_pin_o       = ack_o_q;
    assign host_ack_pin_oe      = ack_oe_q;
    assign host_irq_pin_o       = irq_o_q;
    assign host_irq_pin_oe      = irq_oe_q;
    assign contender_pin_o      = cont_o_q;
    assign contender_pin_oe     = cont_oe_q;
    assign holder_isolation_off = pin_q[ISOLATION_BIT];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ident_read:
        assert property ((s_axi_arvalid && s_axi_arready
                          && rd_word == ADDR_CHIP_IDENT)
                         |=> (s_axi_rvalid
                              && s_axi_rdata == CHIP_IDENT_VALUE))
        else $error("identification word wrong");

    a_irq1_none:
        assert property ((irq1_sel > SRC_LAST) |=> !gpio_irq1_source)
        else $error("irq1 source active with no selection");

    a_irq0_pick:
        assert property ((irq0_sel <= SRC_LAST)
                         |=> gpio_irq0_source
                             == $past(gpio_lvl[irq0_sel]))
        else $error("irq0 source does not follow gpio");

    a_port_a_level:
        assert property (($past(port_a_valid_pin, 3) == port_a_valid_pin
                          && $past(port_a_valid_pin, 2) == port_a_valid_pin
                          && $past(port_a_valid_pin) == port_a_valid_pin
                          && $stable(pin_q) && $past(pin_q, 2) == pin_q)
                         |-> port_a_valid
                             == (port_a_valid_pin
                                 ~^ pin_q[PORT_A_POL_LSB + 3]))
        else $error("port a valid level wrong");

    a_port_b_level:
        assert property (($past(port_b_sync_pin, 3) == port_b_sync_pin
                          && $past(port_b_sync_pin, 2) == port_b_sync_pin
                          && $past(port_b_sync_pin) == port_b_sync_pin
                          && $stable(pin_q) && $past(pin_q, 2) == pin_q)
                         |-> port_b_sync
                             == (port_b_sync_pin ~^ pin_q[PORT_B_POL_LSB]))
        else $error("port b sync level wrong");

    a_isolation_write:
        assert property ((wr_go && wr_pin && w_strb_q[1])
                         |=> holder_isolation_off
                             == $past(w_data_q[ISOLATION_BIT]))
        else $error("isolation bit not written");

    a_reserved_zero:
        assert property (s_axi_rvalid && $past(s_axi_arvalid
                         && s_axi_arready && rd_word == ADDR_PIN_SETUP)
                         |-> (s_axi_rdata & PIN_RSVD_MASK) == '0)
        else $error("reserved bits read nonzero");

    a_contender_dir:
        assert property (contender_pin_oe == $past(pin_q[CONTENDER_BIT]))
        else $error("contender direction wrong");

    a_irq_float:
        assert property ((pin_q[IRQ_FLOAT_BIT] && !host_irq_req)
                         |=> !host_irq_pin_oe)
        else $error("interrupt driver not floated");

    a_ack_float:
        assert property ((pin_q[ACK_FLOAT_BIT] && !host_ack_req)
                         |=> !host_ack_pin_oe)
        else $error("acknowledge driver not floated");

    a_ack_wonly:
        assert property ((wr_go && wr_pin && w_strb_q[0])
                         |=> (pin_q[ACK_POL_RD_BIT]
                              == $past(w_data_q[ACK_POL_WR_BIT]))
                             && !pin_q[ACK_POL_WR_BIT])
        else $error("acknowledge polarity bits wrong");

    a_host_read:
        assert property (($past(host_dir_pin, 3) == host_dir_pin
                          && $past(host_dir_pin, 2) == host_dir_pin
                          && $past(host_dir_pin) == host_dir_pin
                          && $stable(pin_q) && $past(pin_q, 2) == pin_q)
                         |-> host_read
                             == (host_dir_pin ~^ pin_q[HOST_POL_LSB + 2]))
        else $error("host direction decode wrong");

    c_pin_write:
        cover property (wr_go && wr_pin ##1 s_axi_bvalid);
    c_ident_read:
        cover property (s_axi_rvalid && s_axi_rdata == CHIP_IDENT_VALUE);
    c_bad_addr:
        cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_irq1_fire:
        cover property ((irq1_sel <= SRC_LAST) ##1 gpio_irq1_source);

endmodule

// *** spc_host_pins.sv ***
// ****************************************
// Far-side pin driver model
// ****************************************
module spc_host_pins (
    // Intended levels, active high
    input  wire logic [11:0] want,
    // Active level of each pin, 1 is high
    input  wire logic [11:0] act_high,
    // Pin levels
    output logic      [11:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // Active-low pins carry the inverse of the intent
    assign pins = ~(want ^ act_high);
endmodule

// *** system_pin_config_regs_tb.sv ***
module system_pin_config_regs_tb
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals
    // ****************************************
    logic        aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr;
    logic        rv, rr, irq0, irq1, ack_req, irq_req, c_drv, c_in;
    logic        ack_o, ack_oe, irq_o, irq_oe, c_o, c_oe, c_seen, iso;
    logic [11:0] awa, ara, want, pins, lv, act;
    logic [31:0] wd, rd_q;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp;
    logic [9:0]  gpio;
    int          n_mismatch, checks_done;

    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end

    spc_host_pins far (.want(want), .act_high(act), .pins(pins));

    spc_regs uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_q), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .gpio_pin_i(gpio),
        .gpio_irq0_source(irq0), .gpio_irq1_source(irq1),
        .port_a_valid_pin(pins[11]), .port_a_dir_pin(pins[10]),
        .port_a_enable_pin(pins[9]), .port_a_sync_pin(pins[8]),
        .port_a_valid(lv[11]), .port_a_dir(lv[10]),
        .port_a_enable(lv[9]), .port_a_sync(lv[8]),
        .port_b_valid_pin(pins[7]), .port_b_dir_pin(pins[6]),
        .port_b_enable_pin(pins[5]), .port_b_sync_pin(pins[4]),
        .port_b_valid(lv[7]), .port_b_dir(lv[6]),
        .port_b_enable(lv[5]), .port_b_sync(lv[4]),
        .host_strobe_pin(pins[3]), .host_dir_pin(pins[2]),
        .host_select_pin(pins[1]), .host_size_pin(pins[0]),
        .host_strobe(lv[3]), .host_read(lv[2]),
        .host_select(lv[1]), .host_size32(lv[0]),
        .host_ack_req(ack_req), .host_ack_pin_o(ack_o),
        .host_ack_pin_oe(ack_oe), .host_irq_req(irq_req),
        .host_irq_pin_o(irq_o), .host_irq_pin_oe(irq_oe),
        .contender_drive(c_drv), .contender_pin_i(c_in),
        .contender_pin_o(c_o), .contender_pin_oe(c_oe),
        .contender_seen(c_seen), .holder_isolation_off(iso)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic ah, wh;
        @(posedge aclk);
        awa <= a; wd <= d; ws <= 4'hF; awv <= 1; wv <= 1; br <= 1;
        ah = 0; wh = 0;
        while (!(ah && wh)) begin
            @(negedge aclk);
            ah = ah || awr;
            wh = wh || wr_rdy;
            @(posedge aclk);
            if (ah) awv <= 0;
            if (wh) wv <= 0;
        end
        do @(negedge aclk); while (!bv);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
        br <= 0;
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        @(posedge aclk);
        ara <= a; arv <= 1; rr <= 1;
        do @(negedge aclk); while (!arr);
        @(posedge aclk);
        arv <= 0;
        do @(negedge aclk); while (!rv);
        chk(rd_q, e);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
        rr <= 0;
    endtask

    // Drive pins from intent under the given active levels
    task automatic pin_chk(input logic [31:0] cfg, input logic [11:0] w);
        @(posedge aclk);
        act <= {cfg[23:16], cfg[3:0]};
        want <= w;
        repeat (4) @(posedge aclk);
        #1 chk({20'h0, lv}, {20'h0, w});
    endtask

    task automatic out_chk(input logic [5:0] e);
        repeat (3) @(posedge aclk);
        #1 chk({26'h0, iso, c_oe, ack_oe, ack_o, irq_oe, irq_o}, {26'h0, e});
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        n_mismatch = 0; checks_done = 0; aresetn = 0;
        {awv, wv, br, arv, rr, ack_req, irq_req, c_drv, c_in} = '0;
        awa = '0; ara = '0; wd = '0; ws = '0; gpio = '0;
        want = '0; act = 12'hFF4;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        axi_rd(ADDR_CHIP_IDENT, CHIP_IDENT_VALUE, RESP_OKAY);
        axi_wr(ADDR_CHIP_IDENT, 32'h0, RESP_OKAY);
        axi_rd(ADDR_CHIP_IDENT, CHIP_IDENT_VALUE, RESP_OKAY);
        axi_rd(ADDR_PIN_SETUP, PIN_SETUP_RESET, RESP_OKAY);
        out_chk(6'b000101);
        axi_wr(ADDR_PIN_SETUP, 32'hFFFF_FFFF, RESP_OKAY);
        axi_rd(ADDR_PIN_SETUP, 32'hFFFF_931F, RESP_OKAY);
        pin_chk(32'hFFFF_FFFF, 12'h5A3);
        axi_wr(ADDR_PIN_SETUP, 32'h0, RESP_OKAY);
        axi_rd(ADDR_PIN_SETUP, 32'h0, RESP_OKAY);
        pin_chk(32'h0, 12'hA5C);
        gpio <= 10'h008;
        axi_wr(ADDR_PIN_SETUP, 32'h7300_0000, RESP_OKAY);
        repeat (4) @(posedge aclk);
        #1 chk({30'h0, irq1, irq0}, 32'h1);
        gpio <= 10'h3FF;
        axi_wr(ADDR_PIN_SETUP, 32'hAF00_0000, RESP_OKAY);
        repeat (4) @(posedge aclk);
        #1 chk({30'h0, irq1, irq0}, 32'h0);
        axi_wr(ADDR_PIN_SETUP, 32'h9A00_0000, RESP_OKAY);
        repeat (4) @(posedge aclk);
        #1 chk({30'h0, irq1, irq0}, 32'h2);
        ack_req <= 1; irq_req <= 1; c_drv <= 1; c_in <= 1;
        axi_wr(ADDR_PIN_SETUP, 32'h0000_9320, RESP_OKAY);
        out_chk(6'b111110);
        chk({30'h0, c_o, c_seen}, 32'h3);
        ack_req <= 0; irq_req <= 0; c_drv <= 0; c_in <= 0;
        out_chk(6'b110001);
        chk({30'h0, c_o, c_seen}, 32'h0);
        axi_wr(ADDR_PIN_SETUP, 32'h0, RESP_OKAY);
        out_chk(6'b001111);
        axi_rd(12'h008, 32'h0, RESP_SLVERR);
        axi_wr(12'h00C, 32'hFFFF_FFFF, RESP_SLVERR);
        test_done;
    end

    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        test_done;
    end
endmodule
